// [design/dbp_dram_ctrl.sv]
// dram controller path for an external bus master reading an 8-bit bank
// assumes pins arrive asynchronous and are synchronised here; registers over a plain strobe port
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module dbp_dram_ctrl
  import dbp_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic [dbp_pkg::REG_AW-1:0]   reg_addr,
  input  wire logic [31:0]                  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [31:0]                  reg_rdata,
  input  wire logic [dbp_pkg::ADDR_W-1:0]   addr_in,
  output logic      [dbp_pkg::ADDR_W-1:0]   addr_out,
  output logic                              addr_oe,
  input  wire logic                         rw_in,
  input  wire logic [1:0]                   xfer_width,
  input  wire logic                         transfer_start_n,
  output logic                              transfer_ack_n,
  output logic                              transfer_ack_oe,
  output logic                              dram_write_strobe,
  output logic                              dram_write_strobe_oe,
  output logic                              ras_n,
  output logic                              ras_oe,
  output logic                              cas0_n,
  output logic                              cas0_oe,
  input  wire logic [dbp_pkg::BYTE_W-1:0]   data_hi_in
);
  import dbp_pkg::*;

  typedef struct packed {
    dbp_state_e  state;
    logic [27:0] a_s1;
    logic [27:0] a_s2;
    logic        rw_s1;
    logic        rw_s2;
    logic [1:0]  xw_s1;
    logic [1:0]  xw_s2;
    logic        ts_s1;
    logic        ts_s2;
    logic [7:0]  d_s1;
    logic [7:0]  d_s2;
    logic [27:0] cap_addr;
    logic        cap_rw;
    logic [2:0]  beats_left;
    logic [1:0]  beat_idx;
    logic [1:0]  wait_cnt;
    logic        push_pend;
    logic [5:0]  ctrl;
    logic [27:0] base;
    logic [27:0] mask;
    logic        last_hit;
    logic [27:0] a_out;
    logic        a_oe;
    logic        dws;
    logic        dws_oe;
    logic        ta_n;
    logic        ta_oe;
    logic [31:0] rdata;
  } dbp_ctrl_s;

  dbp_ctrl_s st_r;
  dbp_ctrl_s st_nxt;
  logic      ras_n_r;
  logic      cas_n_r;
  logic      strobe_oe_r;
  logic      page_mode;
  logic      edo;
  logic      hit;

  dbp_fifo_if #(.W(BYTE_W), .D(FIFO_DEPTH)) rdq ();

  dbp_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_rdq (
    .clk   (clk),
    .rst_n (rst_n),
    .f     (rdq)
  );

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  assign page_mode = (st_r.ctrl[CTRL_PM_LSB +: 2] == PM_FAST) || (st_r.ctrl[CTRL_PM_LSB +: 2] == PM_BURST);
  assign edo       = st_r.ctrl[CTRL_EDO_BIT] && page_mode;
  assign hit       = st_r.ctrl[CTRL_EN_BIT] && st_r.cap_rw && st_r.ctrl[CTRL_RD_BIT]
                     && (((st_r.cap_addr ^ st_r.base) & st_r.mask) == 28'h0000000);

  assign rdq.in_valid  = st_r.push_pend;
  assign rdq.in_data   = st_r.d_s2;
  assign rdq.out_ready = reg_rd && (reg_addr == REG_DATA);

  // ------------------------------------------------------------
  // sequencer and registers
  // ------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.a_s1  = addr_in;
    st_nxt.a_s2  = st_r.a_s1;
    st_nxt.rw_s1 = rw_in;
    st_nxt.rw_s2 = st_r.rw_s1;
    st_nxt.xw_s1 = xfer_width;
    st_nxt.xw_s2 = st_r.xw_s1;
    st_nxt.ts_s1 = transfer_start_n;
    st_nxt.ts_s2 = st_r.ts_s1;
    st_nxt.d_s1  = data_hi_in;
    st_nxt.d_s2  = st_r.d_s1;
    st_nxt.push_pend = 1'b0;

    unique case (st_r.state)
      DBP_IDLE:
      begin
        if (!st_r.ts_s2)
        begin
          st_nxt.cap_addr   = st_r.a_s2;
          st_nxt.cap_rw     = st_r.rw_s2;
          st_nxt.beats_left = dbp_beats(st_r.xw_s2);
          st_nxt.beat_idx   = 2'h0;
          st_nxt.state      = DBP_DECODE;
        end
      end
      DBP_DECODE:
      begin
        st_nxt.last_hit = hit;
        if (hit)
        begin
          st_nxt.a_out  = st_r.cap_addr;
          st_nxt.a_oe   = 1'b1;
          st_nxt.dws    = 1'b1;
          st_nxt.dws_oe = 1'b1;
          st_nxt.state  = DBP_ROW;
        end
        else
          st_nxt.state = DBP_IDLE;
      end
      DBP_ROW:
      begin
        if (st_r.ctrl[CTRL_RCD_BIT])
          st_nxt.state = DBP_RCD;
        else
        begin
          st_nxt.a_out = dbp_col(st_r.cap_addr, st_r.beat_idx);
          st_nxt.ta_oe = 1'b1;
          st_nxt.ta_n  = 1'b1;
          st_nxt.state = DBP_COL;
        end
      end
      DBP_RCD:
      begin
        st_nxt.a_out = dbp_col(st_r.cap_addr, st_r.beat_idx);
        st_nxt.ta_oe = 1'b1;
        st_nxt.ta_n  = 1'b1;
        st_nxt.state = DBP_COL;
      end
      DBP_COL:
      begin
        if (rdq.in_ready)
        begin
          st_nxt.ta_n  = 1'b0;
          st_nxt.state = DBP_ACK;
        end
      end
      DBP_ACK:
      begin
        st_nxt.ta_n       = 1'b1;
        st_nxt.push_pend  = 1'b1;
        st_nxt.beats_left = st_r.beats_left - 3'h1;
        st_nxt.beat_idx   = st_r.beat_idx + 2'h1;
        if (st_r.beats_left == 3'h1)
          st_nxt.state = DBP_END;
        else if (page_mode)
        begin
          st_nxt.a_out    = dbp_col(st_r.cap_addr, st_r.beat_idx + 2'h1);
          st_nxt.wait_cnt = edo ? CAS_PRE_EDO_CYC : CAS_PRE_STD_CYC;
          st_nxt.state    = DBP_PRE;
        end
        else
        begin
          st_nxt.a_out    = st_r.cap_addr;
          st_nxt.wait_cnt = RAS_PRE_CYC;
          st_nxt.state    = DBP_RPRE;
        end
      end
      DBP_PRE:
      begin
        st_nxt.wait_cnt = st_r.wait_cnt - 2'h1;
        if (st_r.wait_cnt == 2'h1)
          st_nxt.state = DBP_COL;
      end
      DBP_RPRE:
      begin
        st_nxt.wait_cnt = st_r.wait_cnt - 2'h1;
        if (st_r.wait_cnt == 2'h1)
          st_nxt.state = DBP_ROW;
      end
      DBP_END:
      begin
        st_nxt.a_oe   = 1'b0;
        st_nxt.dws    = 1'b0;
        st_nxt.dws_oe = 1'b0;
        st_nxt.ta_oe  = 1'b0;
        st_nxt.state  = DBP_IDLE;
      end
      default:
        st_nxt.state = DBP_IDLE;
    endcase

    if (reg_wr)
    begin
      unique case (reg_addr)
        REG_CTRL: st_nxt.ctrl = reg_wdata[CTRL_W-1:0];
        REG_BASE: st_nxt.base = reg_wdata[ADDR_W-1:0];
        REG_MASK: st_nxt.mask = reg_wdata[ADDR_W-1:0];
        default:  st_nxt.ctrl = st_r.ctrl;
      endcase
    end

    st_nxt.rdata = 32'h00000000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        REG_CTRL: st_nxt.rdata = {26'h0000000, st_r.ctrl};
        REG_BASE: st_nxt.rdata = {4'h0, st_r.base};
        REG_MASK: st_nxt.rdata = {4'h0, st_r.mask};
        REG_STAT: st_nxt.rdata = {27'h0000000, rdq.count, st_r.last_hit, (st_r.state != DBP_IDLE)};
        REG_DATA: st_nxt.rdata = {23'h000000, rdq.out_valid, rdq.out_data};
        default:  st_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r       <= '0;
      st_r.state <= DBP_IDLE;
      st_r.ctrl  <= CTRL_RST;
      st_r.base  <= BASE_RST;
      st_r.mask  <= MASK_RST;
      st_r.ts_s1 <= 1'b1;
      st_r.ts_s2 <= 1'b1;
      st_r.ta_n  <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // ------------------------------------------------------------
  // falling-edge strobes
  // ------------------------------------------------------------
  always_ff @(negedge clk)
  begin
    if (!rst_n)
    begin
      ras_n_r     <= 1'b1;
      cas_n_r     <= 1'b1;
      strobe_oe_r <= 1'b0;
    end
    else
    begin
      strobe_oe_r <= st_r.a_oe;
      ras_n_r     <= !((st_r.state == DBP_ROW) || (st_r.state == DBP_RCD) || (st_r.state == DBP_COL)
                       || (st_r.state == DBP_ACK) || (st_r.state == DBP_PRE));
      cas_n_r     <= !((st_r.state == DBP_COL) || (st_r.state == DBP_ACK));
    end
  end

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  assign reg_rdata            = st_r.rdata;
  assign addr_out             = st_r.a_out;
  assign addr_oe              = st_r.a_oe;
  assign transfer_ack_n       = st_r.ta_n;
  assign transfer_ack_oe      = st_r.ta_oe;
  assign dram_write_strobe    = st_r.dws;
  assign dram_write_strobe_oe = st_r.dws_oe;
  assign ras_n                = ras_n_r;
  assign ras_oe               = strobe_oe_r;
  assign cas0_n               = cas_n_r;
  assign cas0_oe              = strobe_oe_r;
endmodule

// [design/dbp_fifo.sv]
// small flip-flop fifo, parameterised width and depth
// assumes one clock; push and pop may fall in the same cycle
`timescale 1ns/1ps
module dbp_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 4
) (
  input  wire logic clk,
  input  wire logic rst_n,
  dbp_fifo_if.buffer f
);
  localparam int unsigned PW = (D > 1) ? $clog2(D) : 1;
  localparam int unsigned CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0]       wp;
    logic [PW-1:0]       rp;
    logic [CW-1:0]       cnt;
  } dbp_fifo_s;

  dbp_fifo_s st_r;
  dbp_fifo_s st_nxt;
  logic      push;
  logic      pop;

  // ------------------------------------------------------------
  // pointers and count
  // ------------------------------------------------------------
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(D - 1)) ? '0 : p + PW'(1);
  endfunction

  assign f.in_ready  = (st_r.cnt != CW'(D));
  assign f.out_valid = (st_r.cnt != '0);
  assign f.out_data  = st_r.mem[st_r.rp];
  assign f.count     = st_r.cnt;
  assign push        = f.in_valid && f.in_ready;
  assign pop         = f.out_valid && f.out_ready;

  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.mem[st_r.wp] = f.in_data;
      st_nxt.wp = bump(st_r.wp);
    end
    if (pop)
      st_nxt.rp = bump(st_r.rp);
    if (push && !pop)
      st_nxt.cnt = st_r.cnt + CW'(1);
    else if (pop && !push)
      st_nxt.cnt = st_r.cnt - CW'(1);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
endmodule

// [pkg/dbp_fifo_if.sv]
// byte stream between the dram sequencer and its read buffer
// assumes both ends on the same clock
`timescale 1ns/1ps
interface dbp_fifo_if #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 4
);
  logic                   in_valid;
  logic                   in_ready;
  logic [W-1:0]           in_data;
  logic                   out_valid;
  logic                   out_ready;
  logic [W-1:0]           out_data;
  logic [$clog2(D+1)-1:0] count;

  modport buffer (input in_valid, input in_data, output in_ready,
                  output out_valid, output out_data, input out_ready, output count);
  modport user   (output in_valid, output in_data, input in_ready,
                  input out_valid, input out_data, output out_ready, input count);
endinterface

// [pkg/dbp_pkg.sv]
// constants, types and helpers for the external-master dram burst reader
// assumes a 25 MHz system clock and a byte-wide dram bank on the top data lane
package dbp_pkg;

  // ------------------------------------------------------------
  // widths and timing
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W       = 28;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned REG_AW       = 8;
  localparam int unsigned FIFO_DEPTH   = 4;
  localparam int unsigned ROW_LSB      = 9;
  localparam int unsigned CLK_NS       = 40;
  localparam int unsigned CAS_PRE_STD_NS = 60;
  localparam int unsigned CAS_PRE_EDO_NS = 20;
  localparam int unsigned RAS_PRE_NS   = 80;
  localparam int unsigned CAS_PRE_STD_CYC_I = (CAS_PRE_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CAS_PRE_EDO_CYC_I = (CAS_PRE_EDO_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RAS_PRE_CYC_I = (RAS_PRE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] CAS_PRE_STD_CYC = 2'((CAS_PRE_STD_CYC_I < 1) ? 1 : CAS_PRE_STD_CYC_I);
  localparam logic [1:0] CAS_PRE_EDO_CYC = 2'((CAS_PRE_EDO_CYC_I < 1) ? 1 : CAS_PRE_EDO_CYC_I);
  localparam logic [1:0] RAS_PRE_CYC     = 2'((RAS_PRE_CYC_I < 1) ? 1 : RAS_PRE_CYC_I);

  // ------------------------------------------------------------
  // register map and fields
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BASE = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_DATA = 8'h10;
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_PM_LSB  = 1;
  localparam int unsigned CTRL_EDO_BIT = 3;
  localparam int unsigned CTRL_RCD_BIT = 4;
  localparam int unsigned CTRL_RD_BIT  = 5;
  localparam int unsigned CTRL_W       = 6;
  localparam logic [5:0]  CTRL_RST     = 6'h00;
  localparam logic [27:0] BASE_RST     = 28'h0000000;
  localparam logic [27:0] MASK_RST     = 28'h0000000;
  localparam logic [1:0]  PM_NORMAL    = 2'h0;
  localparam logic [1:0]  PM_FAST      = 2'h1;
  localparam logic [1:0]  PM_BURST     = 2'h2;

  // ------------------------------------------------------------
  // transfer width codes
  // ------------------------------------------------------------
  localparam logic [1:0] XW_LONG = 2'h0;
  localparam logic [1:0] XW_BYTE = 2'h1;
  localparam logic [1:0] XW_WORD = 2'h2;
  localparam logic [1:0] XW_LINE = 2'h3;

  typedef enum logic [3:0] {
    DBP_IDLE, DBP_DECODE, DBP_ROW, DBP_RCD, DBP_COL, DBP_ACK, DBP_PRE, DBP_RPRE, DBP_END
  } dbp_state_e;

  // byte beats for an 8-bit bank
  function automatic logic [2:0] dbp_beats(input logic [1:0] xw);
    unique case (xw)
      XW_BYTE: dbp_beats = 3'h1;
      XW_WORD: dbp_beats = 3'h2;
      XW_LONG: dbp_beats = 3'h4;
      XW_LINE: dbp_beats = 3'h4;
    endcase
  endfunction

  // column address on the upper lines, byte offset stepped per beat
  function automatic logic [27:0] dbp_col(input logic [27:0] a, input logic [1:0] idx);
    logic [8:0] col;
    col = a[ROW_LSB-1:0] + {7'h00, idx};
    dbp_col = {a[27:18], col, a[ROW_LSB-1:0]};
  endfunction

endpackage

// [testbench/dbp_checker.sv]
// pin-level assertions for the dram burst reader
// assumes dbp_pkg compiled first; bound into dbp_dram_ctrl
`timescale 1ns/1ps
module dbp_checker
  import dbp_pkg::*;
(
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic [dbp_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0]                reg_wdata,
  input wire logic                       reg_wr,
  input wire logic [dbp_pkg::ADDR_W-1:0] addr_out,
  input wire logic                       addr_oe,
  input wire logic                       transfer_ack_n,
  input wire logic                       transfer_ack_oe,
  input wire logic                       dram_write_strobe,
  input wire logic                       dram_write_strobe_oe,
  input wire logic                       ras_n,
  input wire logic                       ras_oe,
  input wire logic                       cas0_n,
  input wire logic                       cas0_oe
);
  // ------------------------------------------------------------
  // control shadow and properties
  // ------------------------------------------------------------
  logic [5:0] ctrl_r;
  logic       page_w;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  assign page_w = ctrl_r[2:1] != PM_NORMAL;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ctrl_r <= CTRL_RST;
    else if (reg_wr && reg_addr == REG_CTRL)
      ctrl_r <= reg_wdata[5:0];
  end
  row_strobe_a: assert property ($rose(addr_oe) |-> $fell(ras_n) && dram_write_strobe && dram_write_strobe_oe)
    else $error("row strobe not with row address");
  ack_negated_a: assert property ($rose(transfer_ack_oe) |-> transfer_ack_n && !ras_n)
    else $error("ack not driven negated first");
  col_hold_a: assert property (!cas0_n && !$past(cas0_n) |-> $stable(addr_out) && addr_oe && ras_oe)
    else $error("column moved under column strobe");
  ack_cas_a: assert property ($fell(transfer_ack_n) |-> !$past(cas0_n) && !ras_n && cas0_oe)
    else $error("ack without column strobe");
  ack_pulse_a: assert property ($fell(transfer_ack_n) |=> transfer_ack_n)
    else $error("ack longer than one cycle");
  rcd_short_a: assert property ($fell(ras_n) && !ctrl_r[4] |=> $fell(cas0_n) && $changed(addr_out))
    else $error("row to column not one clock");
  rcd_long_a: assert property ($fell(ras_n) && ctrl_r[4] |=> $stable(addr_out) ##1 $fell(cas0_n) && $changed(addr_out))
    else $error("row to column not two clocks");
  pre_std_a: assert property ($rose(cas0_n) && !ras_n && page_w && !ctrl_r[3] |=> cas0_n ##1 !cas0_n)
    else $error("standard precharge wrong");
  pre_edo_a: assert property ($rose(cas0_n) && !ras_n && page_w && ctrl_r[3] |=> !cas0_n)
    else $error("edo precharge wrong");
  burst_end_a: assert property ($rose(ras_n) && page_w |-> $rose(cas0_n) && $rose(transfer_ack_n))
    else $error("burst end not together");
  cover property ($rose(ras_n) && page_w);
  cover property ($fell(ras_n) && ctrl_r[4]);
  cover property ($rose(cas0_n) && !ras_n && ctrl_r[3]);
endmodule

bind dbp_dram_ctrl dbp_checker i_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .addr_out, .addr_oe,
  .transfer_ack_n, .transfer_ack_oe, .dram_write_strobe, .dram_write_strobe_oe, .ras_n, .ras_oe, .cas0_n, .cas0_oe);

// [testbench/dbp_dram_model.sv]
// byte-wide dram on the top data lane
// assumes column bits on addr_out[17:9]; lane carries a running junk byte when not selected
`timescale 1ns/1ps
module dbp_dram_model (
  input  wire logic        clk,
  input  wire logic        cas0_n,
  input  wire logic        cas0_oe,
  input  wire logic [27:0] addr_out,
  output logic      [7:0]  data_hi_in
);
  logic [7:0] col_r;
  logic [7:0] junk_r = 8'h00;
  always @(negedge cas0_n)
    col_r <= addr_out[16:9] ^ 8'h5A;
  always @(posedge clk)
    junk_r <= junk_r + 8'h3B;
  assign data_hi_in = (!cas0_n && cas0_oe) ? col_r : junk_r;
endmodule

// [testbench/dram_burst_page_ext_master_tb_top.sv]
// self-checking bench for the dram burst reader
// assumes dbp_pkg, design, checker and dram model compiled first
`timescale 1ns/1ps
module dram_burst_page_ext_master_tb_top;
  import dbp_pkg::*;
  localparam logic [27:0] HIT  = 28'h1234567;
  localparam logic [27:0] MISS = 28'h2234567;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [REG_AW-1:0] reg_addr = 8'h00;
  logic [31:0]       reg_wdata = 32'h0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [31:0]       reg_rdata;
  logic [ADDR_W-1:0] addr_in = 28'h0;
  logic [ADDR_W-1:0] addr_out;
  logic              addr_oe;
  logic              rw_in = 1'b1;
  logic [1:0]        xfer_width = XW_WORD;
  logic              transfer_start_n = 1'b1;
  logic              transfer_ack_n;
  logic              transfer_ack_oe;
  logic              dram_write_strobe;
  logic              dram_write_strobe_oe;
  logic              ras_n;
  logic              ras_oe;
  logic              cas0_n;
  logic              cas0_oe;
  logic [BYTE_W-1:0] data_hi_in;
  logic [31:0]       d;
  int                fail_count = 0;
  int                checks = 0;
  int                ticks = 0;
  int                c0;
  int                c1;

  dbp_dram_ctrl i_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .addr_in, .addr_out,
    .addr_oe, .rw_in, .xfer_width, .transfer_start_n, .transfer_ack_n, .transfer_ack_oe, .dram_write_strobe,
    .dram_write_strobe_oe, .ras_n, .ras_oe, .cas0_n, .cas0_oe, .data_hi_in);
  dbp_dram_model i_dram (.clk, .cas0_n, .cas0_oe, .addr_out, .data_hi_in);

  // ------------------------------------------------------------
  // clock, timeout and shared tasks
  // ------------------------------------------------------------
  initial
  begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    ticks++;
    if (ticks == 4000)
    begin
      fail_count++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
    @(posedge clk);
  endtask
  // master presents one transfer, then drives the inverted address
  task automatic xfer(input logic [27:0] a, input logic r, input logic [1:0] w, output int acks, output int cyc);
    acks = 0;
    cyc = 0;
    addr_in <= a;
    rw_in <= r;
    xfer_width <= w;
    transfer_start_n <= 1'b0;
    repeat (2) @(posedge clk);
    transfer_start_n <= 1'b1;
    addr_in <= ~a;
    repeat (40)
    begin
      @(posedge clk);
      #10;
      if (addr_oe === 1'b1 || ras_oe === 1'b1 || cas0_oe === 1'b1 || dram_write_strobe_oe === 1'b1)
        cyc++;
      if (transfer_ack_n === 1'b0 && transfer_ack_oe === 1'b1)
        acks++;
    end
    @(posedge clk);
  endtask
  task automatic run(input string nm, input logic [1:0] pm, input logic edo, input logic row_to_col_delay, input logic [1:0] w,
                     input logic [27:0] a, input logic r, input int beats, output int cyc);
    int acks;
    wr(REG_CTRL, {26'h0, 1'b1, row_to_col_delay, edo, pm, 1'b1});
    xfer(a, r, w, acks, cyc);
    check("acks", 32'(acks), 32'(beats));
    rd(REG_STAT, d);
    check("status", d, {27'h0, 3'(beats), beats > 0, 1'b0});
    for (int i = 0; i < beats; i++)
    begin
      rd(REG_DATA, d);
      check("byte", d, {23'h0, 1'b1, (a[7:0] + 8'(i)) ^ 8'h5A});
    end
    rd(REG_DATA, d);
    check("empty", {31'h0, d[8]}, 32'h0);
    $display("test %s done", nm);
  endtask

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(REG_CTRL, d);
    check("ctrl", d, 32'(CTRL_RST));
    rd(REG_MASK, d);
    check("mask", d, 32'(MASK_RST));
    rd(8'h14, d);
    check("unmapped", d, 32'h0);
    wr(REG_BASE, 32'h01000000);
    wr(REG_MASK, 32'h0F000000);
    rd(REG_BASE, d);
    check("base", d, 32'h01000000);
    $display("test registers done");
    run("burst", PM_BURST, 1'b0, 1'b0, XW_WORD, HIT, 1'b1, 2, c0);
    run("edo", PM_BURST, 1'b1, 1'b0, XW_WORD, HIT, 1'b1, 2, c1);
    check("edo length", 32'(c1 + 1), 32'(c0));
    run("rcd", PM_BURST, 1'b0, 1'b1, XW_WORD, HIT, 1'b1, 2, c1);
    check("rcd length", 32'(c1), 32'(c0 + 1));
    run("byte", PM_FAST, 1'b1, 1'b0, XW_BYTE, HIT, 1'b1, 1, c1);
    run("long", PM_BURST, 1'b0, 1'b0, XW_LONG, HIT, 1'b1, 4, c1);
    run("line", PM_BURST, 1'b1, 1'b1, XW_LINE, HIT, 1'b1, 4, c1);
    run("normal", PM_NORMAL, 1'b0, 1'b0, XW_WORD, HIT, 1'b1, 2, c0);
    run("normal edo", PM_NORMAL, 1'b1, 1'b0, XW_WORD, HIT, 1'b1, 2, c1);
    check("normal length", 32'(c1), 32'(c0));
    run("miss", PM_BURST, 1'b0, 1'b0, XW_WORD, MISS, 1'b1, 0, c0);
    run("write", PM_BURST, 1'b0, 1'b0, XW_WORD, HIT, 1'b0, 0, c1);
    check("undriven", 32'(c0 + c1), 32'h0);
    final_report();
  end
endmodule
